// *** verilog/wdt_rst_pkg.sv ***
// constants, register map and carrier types of the watchdog and reset-source block
package wdt_rst_pkg;

  // bus geometry
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned REG_W = 8;

  // register byte offsets (one aligned word each)
  localparam logic [7:0] OFF_WDT_CTRL = 8'h00;
  localparam logic [7:0] OFF_RST_FLAGS = 8'h04;
  localparam logic [7:0] OFF_LV_LEVEL = 8'h08;
  localparam logic [7:0] OFF_LV_FILTER = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;

  // watchdog_control layout and reset value
  localparam logic [7:0] WDT_CTRL_POR = 8'h53;
  localparam int unsigned KEY_LSB = 3;
  localparam int unsigned KEY_W = 5;
  localparam int unsigned SEL_W = 3;
  localparam logic [4:0] KEY_ENABLE_A = 5'h0A;
  localparam logic [4:0] KEY_ENABLE_B = 5'h15;

  // watchdog counter: longest period is 2^18 ticks
  localparam int unsigned WDT_CNT_W = 18;

  // reset_source_flags bit positions; bits above read zero
  localparam int unsigned FLAG_WDT_KEY = 0;
  localparam int unsigned FLAG_LV_LEVEL = 1;
  localparam int unsigned FLAG_LVR = 2;
  localparam int unsigned FLAG_W = 3;

  // status register bit
  localparam int unsigned STAT_TIMEOUT = 0;

  // supply-drop level codes
  localparam logic [7:0] LV_LEVEL_POR = 8'h55;
  localparam logic [7:0] LV_LEVEL_B = 8'h33;
  localparam logic [7:0] LV_LEVEL_C = 8'h99;
  localparam logic [7:0] LV_LEVEL_D = 8'hAA;

  // supply-drop filter widths in low-speed rc ticks
  localparam int unsigned FILT_SEL_W = 2;
  localparam logic [1:0] LV_FILTER_POR = 2'h0;
  localparam int unsigned FILT_CNT_W = 8;
  localparam logic [7:0] FILT_TICKS_0 = 8'h08;
  localparam logic [7:0] FILT_TICKS_1 = 8'h20;
  localparam logic [7:0] FILT_TICKS_2 = 8'h40;
  localparam logic [7:0] FILT_TICKS_3 = 8'h80;

  // default software-reset delay in low-speed rc ticks
  localparam int unsigned SRESET_CNT_W = 8;
  localparam logic [7:0] SRESET_TICKS_DEF = 8'h10;

  // events from the cpu core, same clock
  typedef struct packed {
    logic clear_watchdog_instr;   // clear-watchdog instruction executed
    logic halt;      // halt instruction executed
    logic low_power; // core sits in sleep or idle
  } cpu_evt_t;

  // reset requests to the core, one-cycle pulses
  typedef struct packed {
    logic device;    // whole-device reset
    logic pc_sp;     // program counter and stack pointer only
  } reset_req_t;

  // software-reset delay sequencer
  typedef enum logic [1:0] {
    SR_IDLE = 2'b00,
    SR_WAIT = 2'b01,
    SR_FIRE = 2'b10
  } sreset_state_t;

endpackage : wdt_rst_pkg

// *** verilog/wdt_reset_ctrl.sv ***
// watchdog timer and reset-source logic with an apb register slave
// Behaviour
// - watchdog enabled only by key 01010/10101
// - bad key: delayed reset, set key-fault flag
// - key powers up as 01010, enabled
// - period select picks 2^8 to 2^18 ticks
// - fault flag set by hardware, software clears
// - flag bits 7..3 read as zero
// - running overflow: device reset, set timeout
// - low-power overflow: reset pc/sp, set timeout
// - counter cleared by bad key, clear, halt
// - power-on forces program counter to zero
// - power-on presets port registers to ones
// - supply-drop reset filtered, only when running
// - filtered supply-drop reset sets its flag
// - bad level code: delayed reset, set flag
// - level register powers up as 01010101
// - supply-drop reset off in sleep/idle
// - four level codes valid, else restore
// - filter select picks 8/32/64/128 tick width
// - counter runs from low-speed rc clock
`timescale 1ns/1ps

module wdt_reset_ctrl #(
  parameter logic [7:0] SRESET_TICKS = wdt_rst_pkg::SRESET_TICKS_DEF,
  parameter int unsigned PC_W = 12,
  parameter int unsigned PORT_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [wdt_rst_pkg::ADDR_W-1:0] paddr,
  input wire logic [wdt_rst_pkg::DATA_W-1:0] pwdata,
  output logic [wdt_rst_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic low_speed_rc_osc_clk,
  input wire logic supply_low,
  input wire wdt_rst_pkg::cpu_evt_t cpu_evt,
  output wdt_rst_pkg::reset_req_t reset_req,
  output logic pc_load,
  output logic [PC_W-1:0] pc_value,
  output logic port_preset,
  output logic [PORT_W-1:0] port_value
);

  // register state
  logic [7:0] wdt_ctrl_q;                          // watchdog_control
  logic [wdt_rst_pkg::FLAG_W-1:0] flags_q;         // reset_source_flags
  logic [7:0] lv_level_q;                          // lv_level_register
  logic [wdt_rst_pkg::FILT_SEL_W-1:0] lv_filter_q; // lv_filter_register
  logic timeout_q;                                 // timeout_status_flag
  logic [wdt_rst_pkg::DATA_W-1:0] prdata_q;

  // low-speed rc clock and supply input synchronisers
  logic [2:0] low_speed_rc_osc_sync_q;
  logic low_speed_rc_osc_lvl_q;
  logic [2:0] low_sync_q;
  logic low_lvl_q;
  logic tick;

  // watchdog
  logic [wdt_rst_pkg::WDT_CNT_W-1:0] wdt_cnt_q;
  logic [wdt_rst_pkg::WDT_CNT_W-1:0] wdt_limit;
  logic key_valid;
  logic wdt_overflow;

  // software-reset sequencer
  wdt_rst_pkg::sreset_state_t sr_state_q;
  logic [wdt_rst_pkg::SRESET_CNT_W-1:0] sr_cnt_q;
  logic sr_key_q;   // pending cause: bad key
  logic sr_level_q; // pending cause: bad level code
  logic sr_fire;

  // supply-drop filter
  logic [wdt_rst_pkg::FILT_CNT_W-1:0] filt_cnt_q;
  logic [wdt_rst_pkg::FILT_CNT_W-1:0] filt_limit;
  logic lv_fired_q;
  logic level_valid;
  logic lvr_active;
  logic lvr_fire;

  // reset pulses and power-on
  wdt_rst_pkg::reset_req_t reset_req_q;
  logic por_done_q;
  logic pc_load_q;
  logic port_preset_q;

  // apb decode
  logic wr_en;
  logic rd_setup;
  logic addr_hit;

  assign wr_en = psel && penable && pwrite && addr_hit;
  assign rd_setup = psel && !penable;
  assign addr_hit = (paddr == wdt_rst_pkg::OFF_WDT_CTRL) || (paddr == wdt_rst_pkg::OFF_RST_FLAGS)
                 || (paddr == wdt_rst_pkg::OFF_LV_LEVEL) || (paddr == wdt_rst_pkg::OFF_LV_FILTER)
                 || (paddr == wdt_rst_pkg::OFF_STATUS);

  // zero wait states; read data is latched during setup
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_hit;
  assign prdata = prdata_q;

  // rc clock sampled into the bus domain
  // first stage only feeds the second; level moves when stages two and three agree
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      low_speed_rc_osc_sync_q <= 3'h0;
      low_speed_rc_osc_lvl_q <= 1'b0;
    end
    else
    begin
      low_speed_rc_osc_sync_q <= {low_speed_rc_osc_sync_q[1:0], low_speed_rc_osc_clk};
      if (low_speed_rc_osc_sync_q[1] == low_speed_rc_osc_sync_q[2])
      begin
        low_speed_rc_osc_lvl_q <= low_speed_rc_osc_sync_q[2];
      end
    end
  end

  // one tick per filtered rising edge of the rc clock
  assign tick = (low_speed_rc_osc_sync_q[1] == low_speed_rc_osc_sync_q[2]) && low_speed_rc_osc_sync_q[2] && !low_speed_rc_osc_lvl_q;

  // supply-low indication, same three-stage filter
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      low_sync_q <= 3'h0;
      low_lvl_q <= 1'b0;
    end
    else
    begin
      low_sync_q <= {low_sync_q[1:0], supply_low};
      if (low_sync_q[1] == low_sync_q[2])
      begin
        low_lvl_q <= low_sync_q[2];
      end
    end
  end

  assign key_valid = (wdt_ctrl_q[wdt_rst_pkg::KEY_LSB +: wdt_rst_pkg::KEY_W]
                      == wdt_rst_pkg::KEY_ENABLE_A)
                  || (wdt_ctrl_q[wdt_rst_pkg::KEY_LSB +: wdt_rst_pkg::KEY_W]
                      == wdt_rst_pkg::KEY_ENABLE_B);

  assign level_valid = (lv_level_q == wdt_rst_pkg::LV_LEVEL_POR)
                    || (lv_level_q == wdt_rst_pkg::LV_LEVEL_B)
                    || (lv_level_q == wdt_rst_pkg::LV_LEVEL_C)
                    || (lv_level_q == wdt_rst_pkg::LV_LEVEL_D);

  always_comb
  begin
    unique case (wdt_ctrl_q[wdt_rst_pkg::SEL_W-1:0])
      3'h0: wdt_limit = 18'h000FF;
      3'h1: wdt_limit = 18'h003FF;
      3'h2: wdt_limit = 18'h00FFF;
      3'h3: wdt_limit = 18'h03FFF;
      3'h4: wdt_limit = 18'h07FFF;
      3'h5: wdt_limit = 18'h0FFFF;
      3'h6: wdt_limit = 18'h1FFFF;
      3'h7: wdt_limit = 18'h3FFFF;
    endcase
  end

  always_comb
  begin
    unique case (lv_filter_q)
      2'h0: filt_limit = wdt_rst_pkg::FILT_TICKS_0;
      2'h1: filt_limit = wdt_rst_pkg::FILT_TICKS_1;
      2'h2: filt_limit = wdt_rst_pkg::FILT_TICKS_2;
      2'h3: filt_limit = wdt_rst_pkg::FILT_TICKS_3;
    endcase
  end

  assign wdt_overflow = key_valid && tick && (wdt_cnt_q == wdt_limit);

  // watchdog counter
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wdt_cnt_q <= '0;
    end
    // clear on bad key, clear, halt
    else if (!key_valid || cpu_evt.clear_watchdog_instr || cpu_evt.halt || wdt_overflow)
    begin
      wdt_cnt_q <= '0;
    end
    // counts only with a valid key
    else if (tick)
    begin
      wdt_cnt_q <= wdt_cnt_q + 18'h00001;
    end
  end

  // filter only acts in fast or slow running mode
  assign lvr_active = !cpu_evt.low_power && level_valid;
  // fire once the low level outlasts the width
  assign lvr_fire = lvr_active && low_lvl_q && tick && !lv_fired_q
                 && (filt_cnt_q == filt_limit - 8'h01);

  // supply-drop width counter; a dip shorter than the width restarts it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      filt_cnt_q <= '0;
      lv_fired_q <= 1'b0;
    end
    else if (!lvr_active || !low_lvl_q)
    begin
      filt_cnt_q <= '0;
      lv_fired_q <= 1'b0;
    end
    else if (lvr_fire)
    begin
      // one reset per drop; re-armed when the supply recovers
      lv_fired_q <= 1'b1;
    end
    else if (tick && !lv_fired_q)
    begin
      filt_cnt_q <= filt_cnt_q + 8'h01;
    end
  end

  // delay sequencer shared by both software-reset causes
  assign sr_fire = (sr_state_q == wdt_rst_pkg::SR_FIRE);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sr_state_q <= wdt_rst_pkg::SR_IDLE;
      sr_cnt_q <= '0;
      sr_key_q <= 1'b0;
      sr_level_q <= 1'b0;
    end
    else
    begin
      unique case (sr_state_q)
        wdt_rst_pkg::SR_IDLE:
        begin
          sr_cnt_q <= '0;
          // bad key or bad level code starts the delay
          if (!key_valid || !level_valid)
          begin
            sr_state_q <= wdt_rst_pkg::SR_WAIT;
            sr_key_q <= !key_valid;
            sr_level_q <= !level_valid;
          end
        end
        wdt_rst_pkg::SR_WAIT:
        begin
          // a second cause arriving during the wait joins the same reset
          sr_key_q <= sr_key_q || !key_valid;
          sr_level_q <= sr_level_q || !level_valid;
          if (tick)
          begin
            sr_cnt_q <= sr_cnt_q + 8'h01;
            if (sr_cnt_q == SRESET_TICKS - 8'h01)
            begin
              sr_state_q <= wdt_rst_pkg::SR_FIRE;
            end
          end
        end
        wdt_rst_pkg::SR_FIRE:
        begin
          sr_state_q <= wdt_rst_pkg::SR_IDLE;
          sr_key_q <= 1'b0;
          sr_level_q <= 1'b0;
        end
        default:
        begin
          sr_state_q <= wdt_rst_pkg::SR_IDLE;
        end
      endcase
    end
  end

  // watchdog_control register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wdt_ctrl_q <= wdt_rst_pkg::WDT_CTRL_POR;
    end
    else if (sr_fire && sr_key_q)
    begin
      // key-fault reset returns the control to its power-up value
      wdt_ctrl_q <= wdt_rst_pkg::WDT_CTRL_POR;
    end
    else if (wr_en && (paddr == wdt_rst_pkg::OFF_WDT_CTRL))
    begin
      wdt_ctrl_q <= pwdata[wdt_rst_pkg::REG_W-1:0];
    end
  end

  // level and filter selection registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lv_level_q <= wdt_rst_pkg::LV_LEVEL_POR;
      lv_filter_q <= wdt_rst_pkg::LV_FILTER_POR;
    end
    else
    begin
      // bad code restored at its reset
      if (sr_fire && sr_level_q)
      begin
        lv_level_q <= wdt_rst_pkg::LV_LEVEL_POR;
      end
      else if (wr_en && (paddr == wdt_rst_pkg::OFF_LV_LEVEL))
      begin
        lv_level_q <= pwdata[wdt_rst_pkg::REG_W-1:0];
      end
      if (wr_en && (paddr == wdt_rst_pkg::OFF_LV_FILTER))
      begin
        lv_filter_q <= pwdata[wdt_rst_pkg::FILT_SEL_W-1:0];
      end
    end
  end

  // reset-source flags: software writes zero to clear, a set in the same cycle wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flags_q <= '0;
    end
    else
    begin
      // hardware only sets, software only clears
      if (wr_en && (paddr == wdt_rst_pkg::OFF_RST_FLAGS))
      begin
        flags_q <= flags_q & pwdata[wdt_rst_pkg::FLAG_W-1:0];
      end
      if (sr_fire && sr_key_q)
      begin
        flags_q[wdt_rst_pkg::FLAG_WDT_KEY] <= 1'b1;
      end
      if (sr_fire && sr_level_q)
      begin
        flags_q[wdt_rst_pkg::FLAG_LV_LEVEL] <= 1'b1;
      end
      if (lvr_fire)
      begin
        flags_q[wdt_rst_pkg::FLAG_LVR] <= 1'b1;
      end
    end
  end

  // timeout status: halt or clear-watchdog clears it, an overflow in that cycle wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      timeout_q <= 1'b0;
    end
    else if (wdt_overflow)
    begin
      timeout_q <= 1'b1;
    end
    else if (cpu_evt.halt || cpu_evt.clear_watchdog_instr)
    begin
      timeout_q <= 1'b0;
    end
  end

  // reset request pulses
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      reset_req_q <= '0;
    end
    else
    begin
      reset_req_q.device <= (wdt_overflow && !cpu_evt.low_power) || sr_fire || lvr_fire;
      // low-power overflow resets only pc and sp
      reset_req_q.pc_sp <= wdt_overflow && cpu_evt.low_power;
    end
  end

  assign reset_req = reset_req_q;

  // power-on presets, issued in the first cycle after reset release
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      por_done_q <= 1'b0;
      pc_load_q <= 1'b0;
      port_preset_q <= 1'b0;
    end
    else
    begin
      por_done_q <= 1'b1;
      pc_load_q <= !por_done_q;
      port_preset_q <= !por_done_q;
    end
  end

  assign pc_load = pc_load_q;
  assign pc_value = '0;
  assign port_preset = port_preset_q;
  assign port_value = '1;

  // read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q <= '0;
    end
    else if (rd_setup)
    begin
      prdata_q <= '0;
      unique case (paddr)
        wdt_rst_pkg::OFF_WDT_CTRL: prdata_q[wdt_rst_pkg::REG_W-1:0] <= wdt_ctrl_q;
        wdt_rst_pkg::OFF_RST_FLAGS: prdata_q[wdt_rst_pkg::FLAG_W-1:0] <= flags_q;
        wdt_rst_pkg::OFF_LV_LEVEL: prdata_q[wdt_rst_pkg::REG_W-1:0] <= lv_level_q;
        wdt_rst_pkg::OFF_LV_FILTER: prdata_q[wdt_rst_pkg::FILT_SEL_W-1:0] <= lv_filter_q;
        wdt_rst_pkg::OFF_STATUS: prdata_q[wdt_rst_pkg::STAT_TIMEOUT] <= timeout_q;
        // unmapped reads return zero with pslverr
        default: prdata_q <= '0;
      endcase
    end
  end

endmodule : wdt_reset_ctrl

// *** sim/wdt_reset_ctrl_checker.sv ***
// assertion checker for the watchdog and reset-source block
`timescale 1ns/1ps
module wdt_reset_ctrl_checker #(
  parameter logic [7:0] SRESET_TICKS = 8'h10,
  parameter int unsigned PC_W = 12,
  parameter int unsigned PORT_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire wdt_rst_pkg::cpu_evt_t cpu_evt,
  input wire wdt_rst_pkg::reset_req_t reset_req,
  input wire logic pc_load,
  input wire logic [PC_W-1:0] pc_value,
  input wire logic port_preset,
  input wire logic [PORT_W-1:0] port_value
);
  // cycles since reset release, saturating at 2
  logic [1:0] cyc_q;
  // access phase of a bus transfer
  logic acc;
  assign acc = psel && penable;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // counter restarts at every reset so a mid-run reset is judged too
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cyc_q <= 2'h0;
    else if (cyc_q != 2'h2)
      cyc_q <= cyc_q + 2'h1;
  end
  a_ready_const: assert property (pready == 1'h1)
    else $error("pready dropped");
  a_unmapped_err: assert property (acc |-> pslverr == !(paddr[1:0] == 2'h0
    && paddr <= wdt_rst_pkg::OFF_STATUS)) else $error("pslverr wrong");
  a_load_once: assert property (pc_load == (cyc_q == 2'h1))
    else $error("pc_load not a single pulse after release");
  a_pc_zero: assert property (pc_load |-> pc_value == '0)
    else $error("pc_value not zero");
  a_port_ones: assert property (port_preset |-> pc_load && port_value == '1)
    else $error("port preset wrong");
  a_flag_high_zero: assert property (acc && !pwrite && paddr == 8'h04
    |-> prdata[31:3] == 29'h0) else $error("flag upper bits set");
  a_pcsp_sleep: assert property (reset_req.pc_sp |-> $past(cpu_evt.low_power))
    else $error("pc_sp reset while running");
  a_req_excl: assert property (reset_req.pc_sp |-> !reset_req.device ##1 !reset_req.pc_sp)
    else $error("pc_sp request malformed");
  a_dev_pulse: assert property (reset_req.device |=> !reset_req.device)
    else $error("device request longer than one cycle");
  a_clr_quiet: assert property ((cpu_evt.clear_watchdog_instr || cpu_evt.halt)
    |-> ##2 !reset_req.pc_sp [*6]) else $error("overflow right after clear");
  // main scenarios reached
  cover property (reset_req.pc_sp);
  cover property (reset_req.device);
  cover property (acc && pslverr);
endmodule : wdt_reset_ctrl_checker

bind wdt_reset_ctrl wdt_reset_ctrl_checker #(.SRESET_TICKS(SRESET_TICKS), .PC_W(PC_W),
  .PORT_W(PORT_W)) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .cpu_evt(cpu_evt), .reset_req(reset_req), .pc_load(pc_load), .pc_value(pc_value),
  .port_preset(port_preset), .port_value(port_value));

// *** sim/wdt_reset_ctrl_bench.sv ***
// self-checking bench for the watchdog and reset-source block
`timescale 1ns/1ps
module wdt_reset_ctrl_bench;
  // design ports
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic supply_low, pc_load, port_preset;
  // rc clock and its divider start at rest; only the divider process drives them afterwards
  logic low_speed_rc_osc_clk = 1'h0;
  logic [11:0] pc_value;
  logic [7:0] port_value;
  wdt_rst_pkg::cpu_evt_t cpu_evt;
  wdt_rst_pkg::reset_req_t reset_req;
  // bookkeeping
  int failures, total_checks, n, t;
  int cycles = 0;
  logic [31:0] rd;
  logic er;
  logic [1:0] lc_q = 2'h0;
  // one register access: write flag, address, data, expected read
  typedef struct {logic w; logic [7:0] a; logic [7:0] d; logic [7:0] e;} row_t;
  row_t rows[21] = '{'{1'h0, 8'h00, 8'h00, 8'h53}, '{1'h0, 8'h04, 8'h00, 8'h00},
    '{1'h0, 8'h08, 8'h00, 8'h55}, '{1'h0, 8'h0C, 8'h00, 8'h00}, '{1'h0, 8'h10, 8'h00, 8'h00},
    '{1'h1, 8'h08, 8'h33, 8'h00}, '{1'h0, 8'h08, 8'h00, 8'h33}, '{1'h1, 8'h08, 8'h99, 8'h00},
    '{1'h0, 8'h08, 8'h00, 8'h99}, '{1'h1, 8'h08, 8'hAA, 8'h00}, '{1'h0, 8'h08, 8'h00, 8'hAA},
    '{1'h1, 8'h08, 8'h55, 8'h00}, '{1'h0, 8'h08, 8'h00, 8'h55}, '{1'h1, 8'h0C, 8'hFF, 8'h00},
    '{1'h0, 8'h0C, 8'h00, 8'h03}, '{1'h1, 8'h00, 8'hAB, 8'h00}, '{1'h0, 8'h00, 8'h00, 8'hAB},
    '{1'h1, 8'h00, 8'h53, 8'h00}, '{1'h0, 8'h14, 8'h00, 8'h00}, '{1'h1, 8'h14, 8'hFF, 8'h00},
    '{1'h0, 8'h00, 8'h00, 8'h53}};

  wdt_reset_ctrl #(.SRESET_TICKS(8'h02), .PC_W(12), .PORT_W(8)) u_dut (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .low_speed_rc_osc_clk(low_speed_rc_osc_clk), .supply_low(supply_low), .cpu_evt(cpu_evt), .reset_req(reset_req),
    .pc_load(pc_load), .pc_value(pc_value), .port_preset(port_preset),
    .port_value(port_value));

  // 200 MHz bus clock
  initial
  begin
    pclk = 1'h0;
    forever #2.5 pclk = ~pclk;
  end

  // slow rc clock at one eighth of pclk, free running like the oscillator
  always @(posedge pclk)
  begin
    lc_q <= lc_q + 2'h1;
    if (lc_q == 2'h3)
      low_speed_rc_osc_clk <= ~low_speed_rc_osc_clk;
  end

  // hang guard, well above the longest watchdog period tested
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 100000)
    begin
      failures = failures + 1;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : give_verdict

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e)
    begin
      failures++;
      $display("unexpected %s: expected %h seen %h", nm, e, s);
    end
  endtask : chk

  // apb transfer; result lands in rd and er at the completing edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1)
      @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  // one-cycle clear or halt event from the core
  task automatic evt(input logic h);
    @(posedge pclk);
    cpu_evt.halt <= h;
    cpu_evt.clear_watchdog_instr <= !h;
    @(posedge pclk);
    cpu_evt.halt <= 1'h0;
    cpu_evt.clear_watchdog_instr <= 1'h0;
  endtask : evt

  // count cycles until any reset request, at most mx
  task automatic wait_rq(input int mx);
    n = 0;
    while (reset_req === 2'h0 && n < mx)
    begin
      @(posedge pclk);
      n++;
    end
  endtask : wait_rq

  // power-on reset and the one-cycle preset pulse after release
  task automatic por(input int k);
    presetn <= 1'h0;
    repeat (k) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    #1;
    chk("pc_load", pc_load, 1'h1);
    chk("pc_value", pc_value, 12'h0);
    chk("port_preset", port_preset, 1'h1);
    chk("port_value", port_value, 8'hFF);
  endtask : por

  initial
  begin
    presetn = 1'h0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    supply_low = 1'h0;
    cpu_evt = '0;
    {failures, total_checks} = '0;
    por(12);
    // register table walk
    foreach (rows[i])
    begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w)
        chk("rdata", rd, {24'h0, rows[i].e});
      chk("pslverr", er, rows[i].a > 8'h10);
    end
    // timeouts for three periods running, then one in sleep
    for (int i = 0; i < 4; i++)
    begin
      cpu_evt.low_power <= (i == 3);
      apb(1'h1, 8'h00, {5'h0A, 3'(i % 3)});
      t = 1 << (8 + 2 * (i % 3));
      evt(i == 1);
      wait_rq(t * 8 + 80);
      chk("wdt_gap", n > (t - 2) * 8 && n < t * 8 + 16, 1'h1);
      chk("wdt_req", reset_req, (i == 3) ? 2'h1 : 2'h2);
      apb(1'h0, 8'h10, 8'h00);
      chk("timeout", rd, 32'h1);
      evt(i == 2);
      apb(1'h0, 8'h10, 8'h00);
      chk("timeout", rd, 32'h0);
    end
    cpu_evt.low_power <= 1'h0;
    // bad enable key: delayed reset, flag, control restored
    apb(1'h1, 8'h00, 8'hFB);
    wait_rq(400);
    chk("key_req", reset_req, 2'h2);
    chk("key_gap", n > 8 && n < 30, 1'h1);
    apb(1'h0, 8'h04, 8'h00);
    chk("flags", rd, 32'h1);
    apb(1'h0, 8'h00, 8'h00);
    chk("ctrl", rd, 32'h53);
    apb(1'h1, 8'h04, 8'hFE);
    apb(1'h0, 8'h04, 8'h00);
    chk("flags", rd, 32'h0);
    evt(1'h0);
    // bad level code: delayed reset, flag, level restored
    apb(1'h1, 8'h08, 8'h12);
    wait_rq(400);
    chk("lv_code_req", reset_req, 2'h2);
    apb(1'h0, 8'h04, 8'h00);
    chk("flags", rd, 32'h2);
    apb(1'h0, 8'h08, 8'h00);
    chk("lv_code", rd, 32'h55);
    // filtered supply drop, widest selection first
    for (int f = 3; f >= 0; f--)
    begin
      apb(1'h1, 8'h0C, 8'(f));
      supply_low <= 1'h1;
      t = (f == 0) ? 8 : (16 << f);
      wait_rq(2000);
      chk("lv_gap", n > (t - 2) * 8 && n < t * 8 + 40, 1'h1);
      chk("lv_req", reset_req, 2'h2);
      supply_low <= 1'h0;
      repeat (20) @(posedge pclk);
    end
    // dip of five ticks is shorter than the eight-tick filter; watched while it lasts
    supply_low <= 1'h1;
    wait_rq(40);
    chk("dip_during", n, 40);
    supply_low <= 1'h0;
    wait_rq(150);
    chk("dip_quiet", n, 150);
    apb(1'h0, 8'h04, 8'h00);
    chk("flags", rd, 32'h6);
    // supply drop ignored in sleep
    cpu_evt.low_power <= 1'h1;
    supply_low <= 1'h1;
    wait_rq(300);
    chk("sleep_req", reset_req, 2'h0);
    supply_low <= 1'h0;
    cpu_evt.low_power <= 1'h0;
    // second power-on in mid-run clears the flags
    por(3);
    apb(1'h0, 8'h04, 8'h00);
    chk("flags", rd, 32'h0);
    give_verdict();
  end
endmodule : wdt_reset_ctrl_bench
